/* common/serial_clock_map.svh */
// Register map, field positions and counts of the serial clock block
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses
`ifndef SERIAL_CLOCK_MAP_SVH
`define SERIAL_CLOCK_MAP_SVH
`define OFS_SYSTEM_CONTROL   8'h00
`define OFS_BAUD_CONTROL     8'h04
`define OFS_FRACTIONAL       8'h08
`define OFS_SERIAL_CONTROL   8'h0C
`define OFS_SERIAL_MODE      8'h10
`define OFS_STATUS           8'h14
`define SYS_PRESCALER_LSB    0
`define SYS_ENABLE_BIT       8
`define SYS_SYNC_MODE_BIT    9
`define BAUD_DIVISOR_LSB     0
`define BAUD_TAP_LSB         4
`define BAUD_FRAC_BIT        6
`define SCR_DIRECTION_BIT    0
`define SCR_EDGE_BIT         1
`define PRESCALER_SRC_FC16   2'h2
`define PRESCALER_IN_DIV     2'h3
`define FC16_DIV             4'hF
`define OVERSAMPLE_LAST      4'hF
`define SAMPLE_FIRST         4'h6
`define SAMPLE_MID           4'h7
`define SAMPLE_LAST          4'h8
`define FRAC_PHASES          5'h10
`endif

/* common/serial_clock_pkg.sv */
// Types shared by the serial clock block and its bench
// Assumes serial_clock_map.svh supplies the numbers
package serial_clock_pkg;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_type;
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_type;
    typedef enum logic [1:0] {
        SRC_BAUD   = 2'b00,
        SRC_SYSTEM = 2'b01,
        SRC_TIMER0 = 2'b10,
        SRC_PIN    = 2'b11
    } async_src_type;
    typedef enum logic [1:0] {
        MODE_IDLE     = 2'b00,
        MODE_ASYNC    = 2'b01,
        MODE_SYNC_OUT = 2'b10,
        MODE_SYNC_IN  = 2'b11
    } clock_mode_type;
endpackage : serial_clock_pkg

/* hdl/serial_channel_clock_gen.sv */
// Prescaler, baud generator, basic clock selection and receive sampling
// Assumes one 100 MHz clock; pins come from outside and are synchronised
`include "serial_clock_map.svh"

// Operation
// - A 6-bit prescaler produces the taps for the baud generator.
// - The selected prescaler source is divided by four into the lowest tap.
// - The prescaler runs only while the baud generator is in use.
// - Baud generator input is one of taps divide 1, 4, 16 or 64.
// - A 2-bit tap field in the baud control register picks the tap.
// - Fractional off divides by integer N from 1 to 16.
// - Fractional on in async mode divides by N plus (16-K)/16.
// - External clock gives bit rate f/16 async, f synchronous.
// - Timer 0 match is an async-only source at sixteen times bit rate.
// - Synchronous output mode basic clock is baud output halved.
// - Synchronous input mode detects the selected shift clock edge.
// - Async 2-bit source field picks baud, system, timer or pin clock.
// - A 4-bit counter takes 16 clocks a bit, sampling counts 6, 7, 8.
// - The bit is the majority of the three samples.
// - Output shift clock mode samples receive pin on the selected edge.
// - Input shift clock mode samples receive pin on the selected edge.
module serial_channel_clock_gen (
    // Clock and reset
    input  wire logic                       mclk_in,
    input  wire logic                       reset_in,
    // Register bus
    input  wire serial_clock_pkg::wb_req_type wb_req_in,
    output serial_clock_pkg::wb_rsp_type    wb_rsp_out,
    // Timer and pins
    input  wire logic                       timer0_match_trigger_in,
    input  wire logic                       shift_clock_pin_in,
    output logic                            shift_clock_pin_out,
    output logic                            shift_clock_pin_oe_out,
    input  wire logic                       receive_pin_in,
    // Clock and sample results
    output logic                            bit_clock_out,
    output logic                            oversample_clock_out,
    output logic                            rx_bit_out,
    output logic                            rx_bit_valid_out
);
    import serial_clock_pkg::*;

    logic [1:0]     prescaler_source_select;
    logic           channel_enable;
    logic           sync_mode;
    logic [3:0]     integer_divisor_field;
    logic [1:0]     baud_input_tap_select;
    logic           fractional_divide_enable;
    logic [3:0]     fractional_k_field;
    logic           shift_clock_direction;
    logic           shift_edge_select;
    async_src_type  async_clock_source_select;
    clock_mode_type mode;
    logic [1:0]     sck_sync;
    logic           sck_prev;
    logic [1:0]     rx_sync;
    logic [3:0]     fc16_cnt;
    logic [1:0]     div4_cnt;
    logic [5:0]     pre_cnt;
    logic           pre_run;
    logic           src_pulse;
    logic           prescaler_tap_div1;
    logic           prescaler_tap_div4;
    logic           prescaler_tap_div16;
    logic           prescaler_tap_div64;
    logic           tap;
    logic [4:0]     bd_cnt;
    logic [4:0]     div_len;
    logic [3:0]     frac_phase;
    logic           frac_active;
    logic           baud_pulse;
    logic           sclk;
    logic           next_sclk;
    logic           pin_edge;
    logic           oversample_clock;
    logic [3:0]     rx_cnt;
    logic [2:0]     votes;
    logic           wr;
    logic           rd_hit;
    logic [31:0]    rd_data;

    // Rising edge when sel is low, falling edge when high
    function automatic logic edge_hit(input logic sel, input logic old_v, input logic new_v);
        edge_hit = sel ? (old_v & ~new_v) : (~old_v & new_v);
    endfunction : edge_hit

    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : majority

    always_comb begin
        case ({channel_enable, sync_mode, shift_clock_direction})
            3'b100, 3'b101: mode = MODE_ASYNC;
            3'b110:         mode = MODE_SYNC_OUT;
            3'b111:         mode = MODE_SYNC_IN;
            default:        mode = MODE_IDLE;
        endcase
    end

    // Register bus: one wait state, every access acknowledged
    assign wr = wb_req_in.cyc & wb_req_in.stb & wb_req_in.we & ~wb_rsp_out.ack & wb_req_in.sel[0];

    // One process owns the whole response; unmapped addresses read as zero
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            wb_rsp_out <= '0;
        end else begin
            wb_rsp_out.ack <= wb_req_in.cyc & wb_req_in.stb & ~wb_rsp_out.ack;
            if (wb_req_in.cyc & wb_req_in.stb & ~wb_rsp_out.ack) begin
                wb_rsp_out.dat <= rd_hit ? rd_data : 32'h0;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            prescaler_source_select   <= 2'h0;
            channel_enable            <= 1'b0;
            sync_mode                 <= 1'b0;
            integer_divisor_field     <= 4'h0;
            baud_input_tap_select     <= 2'h0;
            fractional_divide_enable  <= 1'b0;
            fractional_k_field        <= 4'h0;
            shift_clock_direction     <= 1'b0;
            shift_edge_select         <= 1'b0;
            async_clock_source_select <= SRC_BAUD;
        end else if (wr) begin
            case (wb_req_in.adr)
                `OFS_SYSTEM_CONTROL: begin
                    prescaler_source_select <= wb_req_in.dat[`SYS_PRESCALER_LSB +: 2];
                    if (wb_req_in.sel[1]) begin
                        channel_enable <= wb_req_in.dat[`SYS_ENABLE_BIT];
                        sync_mode      <= wb_req_in.dat[`SYS_SYNC_MODE_BIT];
                    end
                end
                `OFS_BAUD_CONTROL: begin
                    integer_divisor_field    <= wb_req_in.dat[`BAUD_DIVISOR_LSB +: 4];
                    baud_input_tap_select    <= wb_req_in.dat[`BAUD_TAP_LSB +: 2];
                    fractional_divide_enable <= wb_req_in.dat[`BAUD_FRAC_BIT];
                end
                `OFS_FRACTIONAL: fractional_k_field <= wb_req_in.dat[3:0];
                `OFS_SERIAL_CONTROL: begin
                    shift_clock_direction <= wb_req_in.dat[`SCR_DIRECTION_BIT];
                    shift_edge_select     <= wb_req_in.dat[`SCR_EDGE_BIT];
                end
                `OFS_SERIAL_MODE: async_clock_source_select <= async_src_type'(wb_req_in.dat[1:0]);
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h0;
        case (wb_req_in.adr)
            `OFS_SYSTEM_CONTROL: begin
                rd_data[1:0] = prescaler_source_select;
                rd_data[`SYS_ENABLE_BIT]    = channel_enable;
                rd_data[`SYS_SYNC_MODE_BIT] = sync_mode;
            end
            `OFS_BAUD_CONTROL: rd_data[6:0] = {fractional_divide_enable, baud_input_tap_select,
                                               integer_divisor_field};
            `OFS_FRACTIONAL:     rd_data[3:0] = fractional_k_field;
            `OFS_SERIAL_CONTROL: rd_data[1:0] = {shift_edge_select, shift_clock_direction};
            `OFS_SERIAL_MODE:    rd_data[1:0] = async_clock_source_select;
            `OFS_STATUS:         rd_data[7:0] = {pre_run, sclk, rx_cnt, rx_bit_out, 1'b0};
            default:             rd_hit = 1'b0;
        endcase
    end

    // Pin synchronisers; first stage read only by the second
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sck_sync <= 2'b11;
            sck_prev <= 1'b1;
            rx_sync  <= 2'b11;
        end else begin
            sck_sync <= {sck_sync[0], shift_clock_pin_in};
            sck_prev <= sck_sync[1];
            rx_sync  <= {rx_sync[0], receive_pin_in};
        end
    end

    // Prescaler stops outside baud generator use to save power
    assign pre_run = (mode == MODE_SYNC_OUT) ||
                     (mode == MODE_ASYNC && async_clock_source_select == SRC_BAUD);
    assign src_pulse = (prescaler_source_select == `PRESCALER_SRC_FC16) ? (fc16_cnt == `FC16_DIV) : 1'b1;

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            fc16_cnt <= 4'h0;
            div4_cnt <= 2'h0;
            pre_cnt  <= 6'h0;
        end else if (!pre_run) begin
            fc16_cnt <= 4'h0;
            div4_cnt <= 2'h0;
            pre_cnt  <= 6'h0;
        end else begin
            fc16_cnt <= fc16_cnt + 4'h1;
            if (src_pulse) begin
                div4_cnt <= div4_cnt + 2'h1;
            end
            if (prescaler_tap_div1) begin
                pre_cnt <= pre_cnt + 6'h1;
            end
        end
    end

    assign prescaler_tap_div1  = pre_run & src_pulse & (div4_cnt == `PRESCALER_IN_DIV);
    assign prescaler_tap_div4  = prescaler_tap_div1 & (pre_cnt[1:0] == 2'h3);
    assign prescaler_tap_div16 = prescaler_tap_div1 & (pre_cnt[3:0] == 4'hF);
    assign prescaler_tap_div64 = prescaler_tap_div1 & (pre_cnt == 6'h3F);

    always_comb begin
        case (baud_input_tap_select)
            2'h0:    tap = prescaler_tap_div1;
            2'h1:    tap = prescaler_tap_div4;
            2'h2:    tap = prescaler_tap_div16;
            default: tap = prescaler_tap_div64;
        endcase
    end

    // Fraction honoured only in async mode; the enable is masked in other modes
    assign frac_active = fractional_divide_enable & (mode == MODE_ASYNC);
    always_comb begin
        div_len = (integer_divisor_field == 4'h0) ? 5'h10 : {1'b0, integer_divisor_field};
        if (frac_active && ({1'b0, frac_phase} < (`FRAC_PHASES - {1'b0, fractional_k_field}))) begin
            div_len = div_len + 5'h1;
        end
    end
    assign baud_pulse = tap & (bd_cnt >= div_len - 5'h1);

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            bd_cnt     <= 5'h0;
            frac_phase <= 4'h0;
        end else if (!pre_run) begin
            bd_cnt     <= 5'h0;
            frac_phase <= 4'h0;
        end else if (baud_pulse) begin
            bd_cnt     <= 5'h0;
            frac_phase <= frac_phase + 4'h1;
        end else if (tap) begin
            bd_cnt <= bd_cnt + 5'h1;
        end
    end

    // Shift clock idles high; toggles on each baud pulse in synchronous output mode
    assign next_sclk = (mode == MODE_SYNC_OUT) ? (sclk ^ baud_pulse) : 1'b1;
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk <= 1'b1;
        end else begin
            sclk <= next_sclk;
        end
    end
    assign shift_clock_pin_out    = sclk;
    assign shift_clock_pin_oe_out = (mode == MODE_SYNC_OUT);

    assign pin_edge = ~sck_prev & sck_sync[1];
    always_comb begin
        case (async_clock_source_select)
            SRC_BAUD:   oversample_clock = baud_pulse;
            SRC_SYSTEM: oversample_clock = 1'b1;
            SRC_TIMER0: oversample_clock = timer0_match_trigger_in;
            SRC_PIN:    oversample_clock = pin_edge;
            default:    oversample_clock = 1'b0;
        endcase
    end

    // Async oversampling; start bit alignment is left to the receiver
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_cnt <= 4'h0;
            votes  <= 3'h0;
        end else if (mode != MODE_ASYNC) begin
            rx_cnt <= 4'h0;
        end else if (oversample_clock) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == `SAMPLE_FIRST) votes[0] <= rx_sync[1];
            if (rx_cnt == `SAMPLE_MID)   votes[1] <= rx_sync[1];
            if (rx_cnt == `SAMPLE_LAST)  votes[2] <= rx_sync[1];
        end
    end

    // Bit clock, oversample pulse and received bit per mode
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            bit_clock_out        <= 1'b0;
            oversample_clock_out <= 1'b0;
            rx_bit_out           <= 1'b1;
            rx_bit_valid_out     <= 1'b0;
        end else begin
            bit_clock_out        <= 1'b0;
            oversample_clock_out <= 1'b0;
            rx_bit_valid_out     <= 1'b0;
            case (mode)
                MODE_ASYNC: begin
                    oversample_clock_out <= oversample_clock;
                    if (oversample_clock && rx_cnt == `OVERSAMPLE_LAST) begin
                        bit_clock_out    <= 1'b1;
                        rx_bit_out       <= majority(votes);
                        rx_bit_valid_out <= 1'b1;
                    end
                end
                MODE_SYNC_OUT: begin
                    bit_clock_out <= ~sclk & next_sclk;
                    if (edge_hit(shift_edge_select, sclk, next_sclk)) begin
                        rx_bit_out       <= rx_sync[1];
                        rx_bit_valid_out <= 1'b1;
                    end
                end
                MODE_SYNC_IN: begin
                    if (edge_hit(shift_edge_select, sck_prev, sck_sync[1])) begin
                        bit_clock_out    <= 1'b1;
                        rx_bit_out       <= rx_sync[1];
                        rx_bit_valid_out <= 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    sequence s_quiet3;
        !prescaler_tap_div1 [*3];
    endsequence

    property p_div4;
        @(posedge mclk_in) disable iff (reset_in) prescaler_tap_div1 |=> s_quiet3;
    endproperty
    a_div4: assert property (p_div4) else $error("Prescaler input tap faster than one in four");

    property p_stop;
        @(posedge mclk_in) disable iff (reset_in) !pre_run |=> (pre_cnt == 6'h0 && bd_cnt == 5'h0);
    endproperty
    a_stop: assert property (p_stop) else $error("Prescaler counting while stopped");

    property p_taps;
        @(posedge mclk_in) disable iff (reset_in)
            prescaler_tap_div64 |-> (prescaler_tap_div16 && prescaler_tap_div4 && pre_cnt == 6'h3F);
    endproperty
    a_taps: assert property (p_taps) else $error("Prescaler taps misaligned");

    sequence s_int2_cfg;
        pre_run && prescaler_source_select == 2'h0 && baud_input_tap_select == 2'h0
            && integer_divisor_field == 4'h2 && !frac_active;
    endsequence

    property p_int2;
        @(posedge mclk_in) disable iff (reset_in)
            (baud_pulse and s_int2_cfg) ##1 s_int2_cfg [*8] |-> baud_pulse && !$past(baud_pulse, 4);
    endproperty
    a_int2: assert property (p_int2) else $error("Integer divide by two spacing wrong");

    property p_system_src;
        @(posedge mclk_in) disable iff (reset_in)
            (mode == MODE_ASYNC && async_clock_source_select == SRC_SYSTEM) |=> oversample_clock_out;
    endproperty
    a_system_src: assert property (p_system_src) else $error("System clock source missed");

    property p_bit_end;
        @(posedge mclk_in) disable iff (reset_in)
            (mode == MODE_ASYNC && oversample_clock && rx_cnt == 4'hF) |=> (rx_bit_valid_out && rx_cnt == 4'h0);
    endproperty
    a_bit_end: assert property (p_bit_end) else $error("Bit not decided after sixteen counts");

    property p_majority;
        @(posedge mclk_in) disable iff (reset_in)
            (rx_bit_valid_out && mode == MODE_ASYNC) |-> rx_bit_out == majority($past(votes));
    endproperty
    a_majority: assert property (p_majority) else $error("Received bit is not the vote");

    property p_sync_out_clock;
        @(posedge mclk_in) disable iff (reset_in)
            (bit_clock_out && $past(mode) == MODE_SYNC_OUT) |-> (sclk && !$past(sclk));
    endproperty
    a_sync_out_clock: assert property (p_sync_out_clock) else $error("Basic clock not on shift rise");

    property p_sync_in_edge;
        @(posedge mclk_in) disable iff (reset_in)
            (mode == MODE_SYNC_IN && edge_hit(shift_edge_select, sck_prev, sck_sync[1]))
                |=> (bit_clock_out && rx_bit_valid_out && rx_bit_out == $past(rx_sync[1]));
    endproperty
    a_sync_in_edge: assert property (p_sync_in_edge) else $error("Input shift edge not sampled");

endmodule : serial_channel_clock_gen

/* dv/serial_remote_model.sv */
// Remote serial device on the shift clock and receive pins
// Assumes the bench calls its tasks; it moves pins just after rising edges of mclk_in
module serial_remote_model (
    // Clock
    input  wire logic mclk_in,
    // Pins
    output logic      shift_clock_pin_out,
    output logic      receive_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock idles high between frames
    initial begin
        shift_clock_pin_out = 1'b1;
        receive_pin_out     = 1'b1;
    end
    task automatic set_line(input logic v);
        @(posedge mclk_in);
        receive_pin_out <= v;
    endtask : set_line
    // Data launched half a period before the sampling edge
    // Half period 3 gives 7 cycles, legal async only; sync needs 8 or more
    task automatic shift_frame(input logic [15:0] bits, input int n, input int half, input bit rise);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk_in);
            if (rise) shift_clock_pin_out <= 1'b0;
            receive_pin_out <= bits[i];
            repeat (half) @(posedge mclk_in);
            shift_clock_pin_out <= rise;
            repeat (half) @(posedge mclk_in);
            shift_clock_pin_out <= 1'b1;
        end
        // Released line must not keep the last bit
        receive_pin_out <= ~receive_pin_out;
    endtask : shift_frame
endmodule : serial_remote_model

/* dv/serial_channel_clock_gen_tb_top.sv */
// Bench for the serial clock block: register tasks and pin scenarios
// Assumes the remote model owns the pins; timer match pulses come from here
`include "serial_clock_map.svh"
module serial_channel_clock_gen_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import serial_clock_pkg::*;
    logic       mclk_in = 1'b0;
    logic       reset_in = 1'b1;
    wb_req_type wb_req = '0;
    wb_rsp_type wb_rsp;
    logic       timer0_match = 1'b0;
    logic       sclk_model, sclk_drv, sclk_oe, sclk_wire, rx_pin;
    logic       bit_clock, oversample, rx_bit, rx_valid;
    int         fails = 0, comparisons = 0, cycles = 0, over_count = 0, bit_count = 0, cyc;
    logic       rx_seen[$];
    logic [31:0] r;
    logic [1:0] taps[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    logic [3:0] divs[8] = '{4'h1, 4'h2, 4'h0, 4'hF, 4'h1, 4'h1, 4'h1, 4'h1};
    logic [2:0] pat;
    logic       maj;
    always #5 mclk_in = ~mclk_in;
    // Wire level from both parties
    assign sclk_wire = sclk_oe ? sclk_drv : sclk_model;
    serial_channel_clock_gen i_dut (.mclk_in(mclk_in), .reset_in(reset_in), .wb_req_in(wb_req),
        .wb_rsp_out(wb_rsp), .timer0_match_trigger_in(timer0_match), .shift_clock_pin_in(sclk_wire),
        .shift_clock_pin_out(sclk_drv), .shift_clock_pin_oe_out(sclk_oe), .receive_pin_in(rx_pin),
        .bit_clock_out(bit_clock), .oversample_clock_out(oversample), .rx_bit_out(rx_bit),
        .rx_bit_valid_out(rx_valid));
    serial_remote_model i_remote (.mclk_in(mclk_in), .shift_clock_pin_out(sclk_model),
        .receive_pin_out(rx_pin));
    task automatic conclude;
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    always @(posedge mclk_in) begin
        cycles++;
        if (oversample === 1'b1) over_count++;
        if (bit_clock === 1'b1) bit_count++;
        if (rx_valid === 1'b1) rx_seen.push_back(rx_bit);
        if (cycles > 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            fails++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic wb_access(input logic we, input logic [7:0] adr, input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge mclk_in);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wdat};
        do @(posedge mclk_in); while (wb_rsp.ack !== 1'b1);
        rdat = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb_access
    task automatic rd(input logic [7:0] adr, input logic [31:0] expected);
        logic [31:0] v;
        wb_access(1'b0, adr, 32'h0, v);
        check(v, expected);
    endtask : rd
    task automatic cfg(input logic [31:0] sys, baud, k, scr, mode);
        wb_access(1'b1, `OFS_SYSTEM_CONTROL, 32'h0, r);
        wb_access(1'b1, `OFS_BAUD_CONTROL, baud, r);
        wb_access(1'b1, `OFS_FRACTIONAL, k, r);
        wb_access(1'b1, `OFS_SERIAL_CONTROL, scr, r);
        wb_access(1'b1, `OFS_SERIAL_MODE, mode, r);
        wb_access(1'b1, `OFS_SYSTEM_CONTROL, sys, r);
        repeat (8) @(posedge mclk_in);
    endtask : cfg
    // Cycles spanned by n pulses, after two settling pulses
    task automatic measure(input bit use_bit, input int n, output int span);
        int seen;
        seen = -2;
        span = 0;
        while (seen < n) begin
            @(posedge mclk_in);
            if (seen >= 0) span++;
            if ((use_bit ? bit_clock : oversample) === 1'b1) seen++;
        end
    endtask : measure
    task automatic tick;
        repeat (4) @(posedge mclk_in);
        timer0_match <= 1'b1;
        @(posedge mclk_in);
        timer0_match <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask : tick
    initial begin
        repeat (2) @(posedge mclk_in);
        reset_in <= 1'b0;
        rd(`OFS_SYSTEM_CONTROL, 32'h0);
        rd(`OFS_BAUD_CONTROL, 32'h0);
        rd(`OFS_STATUS, 32'h0000_0042);
        wb_access(1'b1, 8'h20, 32'hFFFF_FFFF, r);
        rd(8'h20, 32'h0);
        wb_access(1'b1, `OFS_FRACTIONAL, 32'hFFFF_FFFF, r);
        rd(`OFS_FRACTIONAL, 32'h0000_000F);
        over_count = 0;
        repeat (100) @(posedge mclk_in);
        check(over_count, 0);
        // Last entry runs the prescaler from the divide-by-16 source
        for (int i = 0; i < 8; i++) begin
            cfg(32'h100 | (i == 7 ? 32'h2 : 32'h0), {26'h0, taps[i], divs[i]}, 32'h0, 32'h0, SRC_BAUD);
            measure(1'b0, 1, cyc);
            check(cyc, (4 << (2 * taps[i])) * (divs[i] == 4'h0 ? 16 : divs[i])
                       * (i == 7 ? 16 : 1));
        end
        wb_access(1'b0, `OFS_STATUS, 32'h0, r);
        check(r[7], 1'b1);
        cfg(32'h100, 32'h42, 32'h8, 32'h0, SRC_BAUD);
        measure(1'b0, 16, cyc);
        check(cyc, 160);
        cfg(32'h100, 32'h0, 32'h0, 32'h0, SRC_TIMER0);
        wb_access(1'b0, `OFS_STATUS, 32'h0, r);
        check(r[7], 1'b0);
        repeat ((16 - r[5:2]) % 16) tick();
        rx_seen.delete();
        for (int p = 0; p < 8; p++) begin
            pat = p[2:0];
            maj = (pat[0] & pat[1]) | (pat[0] & pat[2]) | (pat[1] & pat[2]);
            for (int c = 0; c < 16; c++) begin
                i_remote.set_line((c >= 6 && c <= 8) ? pat[c - 6] : ~maj);
                tick();
            end
            check(rx_bit, maj);
        end
        check(rx_seen.size(), 8);
        cfg(32'h100, 32'h0, 32'h0, 32'h0, SRC_PIN);
        over_count = 0;
        i_remote.shift_frame(16'h0, 16, 3, 1'b1);
        repeat (8) @(posedge mclk_in);
        check(over_count, 16);
        cfg(32'h100, 32'h0, 32'h0, 32'h0, SRC_SYSTEM);
        measure(1'b0, 1, cyc);
        check(cyc, 1);
        for (int e = 0; e < 2; e++) begin
            // Fraction enable left clear in synchronous mode; K of 8 written but unused
            cfg(32'h300, 32'h02, 32'h8, e << 1, SRC_BAUD);
            check(sclk_oe, 1'b1);
            measure(1'b1, 1, cyc);
            check(cyc, 16);
            check(sclk_drv, 1'b1);
            repeat (8) @(posedge mclk_in);
            check(sclk_drv, 1'b0);
            for (int v = 0; v < 2; v++) begin
                i_remote.set_line(v[0]);
                measure(1'b1, 2, cyc);
                check(rx_seen[$], v[0]);
            end
        end
        for (int e = 0; e < 2; e++) begin
            cfg(32'h300, 32'h02, 32'h0, 32'h1 | (e << 1), SRC_BAUD);
            check(sclk_oe, 1'b0);
            rx_seen.delete();
            bit_count = 0;
            i_remote.shift_frame(16'h00A5, 8, 10, e == 0);
            repeat (8) @(posedge mclk_in);
            check(bit_count, 8);
            check(rx_seen.size(), 8);
            for (int i = 0; i < 8; i++) check(rx_seen[i], 8'hA5 >> i & 1);
        end
        conclude();
    end
endmodule : serial_channel_clock_gen_tb_top
